// [core/uart_rx_dma_modem.sv]
// Receiver, host read port, ring status, request-to-send and receive DMA ready
`timescale 1ns/100ps
module uart_rx_dma_modem
    import uart_rx_pkg::*;
#(
    parameter int DEPTH = uart_rx_pkg::FIFO_DEPTH
) (
    input  wire logic                   clk,          // 25 MHz system clock
    input  wire logic                   rst,          // Master reset, high
    input  wire uart_rx_pkg::host_bus_t hostBus,      // Host read pins
    output logic [7:0]                  dataOut,      // Read data
    output logic                        dataOutEn,    // Drives data bus
    input  wire uart_rx_pkg::ctrl_t     ctrl,         // Software control bits
    input  wire logic                   rxSerial,     // Serial data pin
    input  wire logic                   rcvClk16,     // 16x baud clock pin
    input  wire logic                   ringInd_n,    // Ring indicator pin
    output logic                        rts_n,        // Request to send
    output logic                        rx_dma_ready_n, // Receive DMA ready
    output logic                        modemIrq,     // Modem status interrupt
    output logic                        overrun       // Character lost, pulse
);
    import uart_rx_pkg::*;

    if (DEPTH < 16) begin : g_bad_depth
        $error("depth must hold the highest trigger level");
    end

    localparam int LW = $clog2(DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [8:0] pinRaw;
    logic [8:0] pinSync;
    logic       csS;
    logic       rdHighS;
    logic       rdLowS_n;
    logic [2:0] addrS;
    logic       rxS;
    logic       rclkS;
    logic       ringS_n;

    assign pinRaw = {rcvClk16, ringInd_n, rxSerial, hostBus};
    assign {rclkS, ringS_n, rxS, csS, rdHighS, rdLowS_n, addrS} = pinSync;

    // Idle levels: ring and strobe high, line marking
    pin_sync #(
        .W         (9),
        .RESET_VAL (9'h0c8)
    ) u_sync (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (pinRaw),
        .pinOut (pinSync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Receiver on 16x baud ticks

    logic           rclkPrev;
    logic           tick;
    rx_state_t      rxState;
    rx_state_t      next_rxState;
    logic [3:0]     phase;
    logic [2:0]     bitIdx;
    logic [7:0]     shiftReg;
    logic           charDone;
    logic           pend;
    logic [7:0]     pendData;
    logic           phaseEnd;
    logic           phaseMid;

    // Baud clock must stay below a quarter of clk for edges to be seen
    assign tick     = rclkS & ~rclkPrev;
    assign phaseEnd = phase == 4'(OVERSAMPLE - 1);
    assign phaseMid = phase == 4'(SAMPLE_MID);
    assign charDone = tick & (rxState == RX_STOP) & phaseEnd & rxS;

    // Receiver state decode
    always_comb begin
        next_rxState = rxState;
        unique case (rxState)
            RX_IDLE:  if (!rxS) next_rxState = RX_START;
            RX_START: if (phaseMid) next_rxState = rxS ? RX_IDLE : RX_DATA;
            RX_DATA:  if (phaseEnd && bitIdx == 3'h7) next_rxState = RX_STOP;
            RX_STOP:  if (phaseEnd) next_rxState = RX_IDLE;
        endcase
    end

    // Start is centred, later bits land mid-cell sixteen ticks apart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rclkPrev <= 1'b0;
            rxState  <= RX_IDLE;
            phase    <= 4'h0;
            bitIdx   <= 3'h0;
            shiftReg <= 8'h00;
        end else begin
            rclkPrev <= rclkS;
            if (tick) begin
                rxState <= next_rxState;
                phase   <= (rxState != next_rxState) ? 4'h0 : phase + 4'h1;
                if (rxState == RX_DATA && phaseEnd) begin
                    shiftReg <= {rxS, shiftReg[7:1]};
                    bitIdx   <= bitIdx + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holding stage and FIFO

    logic          fifoMode;
    logic          dmaMode1;
    logic          fifoInReady;
    logic          fifoValid;
    logic [7:0]    fifoHead;
    logic [LW-1:0] fifoLevel;
    logic          push;
    logic          pop;
    logic          next_pend;

    assign fifoMode = ctrl.fifoControlReg[FCR_ENABLE_BIT];
    // Without FIFOs the FIFO holds only one character, as a plain holding register
    assign push      = pend & fifoInReady & (fifoMode | ~fifoValid);
    assign next_pend = charDone | (pend & ~push);

    // Pending byte waits for room; a second byte meanwhile is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend     <= 1'b0;
            pendData <= 8'h00;
            overrun  <= 1'b0;
        end else begin
            pend     <= next_pend;
            overrun  <= charDone & pend & ~push;
            if (charDone && (!pend || push)) begin
                pendData <= shiftReg;
            end
        end
    end

    rx_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (push),
        .inReady  (fifoInReady),
        .inData   (pendData),
        .outValid (fifoValid),
        .outReady (pop),
        .outData  (fifoHead),
        .level    (fifoLevel)
    );

    ////////////////////////////////////////////////////////////////////////
    // Host read port

    logic       readActive;
    logic       readPrev;
    logic       readStart;
    logic       msrRead;
    logic [7:0] msrValue;
    logic [7:0] next_dataOut;
    logic       ringLevel;
    logic       ringPrev_n;
    logic       ringRise;
    logic       ring_rise_flag;

    assign readActive = csS & (rdHighS | ~rdLowS_n);
    assign readStart  = readActive & ~readPrev;
    assign pop        = readStart & (addrS == ADDR_RX_DATA);
    assign msrRead    = readStart & (addrS == ADDR_MODEM_STATUS);
    assign ringLevel  = ~ringS_n;
    assign msrValue   = (8'(ringLevel) << MSR_RING_LEVEL_BIT)
                      | (8'(ring_rise_flag) << MSR_RING_RISE_BIT);
    // Unmapped addresses read as zero
    assign next_dataOut = (addrS == ADDR_RX_DATA)      ? fifoHead :
                          (addrS == ADDR_MODEM_STATUS) ? msrValue : 8'h00;

    // Data is latched at strobe start so it holds steady for the whole cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readPrev  <= 1'b0;
            dataOut   <= 8'h00;
            dataOutEn <= 1'b0;
        end else begin
            readPrev  <= readActive;
            dataOutEn <= readActive;
            if (readStart) begin
                dataOut <= next_dataOut;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring indicator edge flag

    assign ringRise = ringS_n & ~ringPrev_n;
    assign modemIrq = ctrl.modemIntEnable & ring_rise_flag;

    // A new edge wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ringPrev_n     <= 1'b1;
            ring_rise_flag <= 1'b0;
        end else begin
            ringPrev_n     <= ringS_n;
            ring_rise_flag <= ringRise | (ring_rise_flag & ~msrRead);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request to send

    logic [4:0] trigChars;
    logic       trigHit;
    logic       autoRts;
    logic       autoHold;
    logic       rtsWanted;

    assign trigChars = trigLevel(ctrl.fifoControlReg[FCR_TRIG_LSB +: 2]);
    assign trigHit   = fifoLevel >= LW'(trigChars);
    assign autoRts   = fifoMode & ctrl.modemControlReg[MCR_AUTOFLOW_BIT];
    assign rtsWanted = ctrl.modemControlReg[MCR_RTS_BIT]
                     & ~ctrl.modemControlReg[MCR_LOOP_BIT]
                     & ~(autoRts & autoHold);

    // Hold off from trigger until drained, so the line does not chatter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            autoHold <= 1'b0;
            rts_n    <= 1'b1;
        end else begin
            autoHold <= trigHit | (autoHold & fifoValid);
            rts_n    <= ~rtsWanted;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive timeout and DMA ready

    logic [9:0] idleCount;
    logic       timeoutHit;
    logic       mode1Active;
    logic       next_readyN;

    assign dmaMode1   = fifoMode & ctrl.fifoControlReg[FCR_DMA_SELECT_BIT];
    assign timeoutHit = idleCount == 10'(TIMEOUT_TICKS);
    assign next_readyN = dmaMode1 ? ~(mode1Active | trigHit | timeoutHit)
                                  : ~fifoValid;

    // Timeout counts ticks since the last push or pop while data waits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idleCount      <= 10'h000;
            mode1Active    <= 1'b0;
            rx_dma_ready_n <= 1'b1;
        end else begin
            if (push || pop || !fifoValid) begin
                idleCount <= 10'h000;
            end else if (tick && !timeoutHit) begin
                idleCount <= idleCount + 10'h001;
            end
            mode1Active    <= (mode1Active | trigHit | timeoutHit) & fifoValid;
            rx_dma_ready_n <= next_readyN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_read_qualify: assert property (
        readActive |=> dataOutEn)
        else $error("qualified read did not enable the data bus");

    a_msr_data: assert property (
        msrRead |=> dataOut == $past(msrValue))
        else $error("modem status not driven on read");

    a_ring_level: assert property (
        msrRead |=> dataOut[MSR_RING_LEVEL_BIT] == !$past(ringS_n))
        else $error("ring level bit wrong");

    a_ring_flag_set: assert property (
        ringRise |=> ring_rise_flag)
        else $error("ring edge flag not set");

    a_ring_irq: assert property (
        ringRise && ctrl.modemIntEnable |=> modemIrq || !ctrl.modemIntEnable)
        else $error("ring edge raised no interrupt");

    a_ring_clear: assert property (
        msrRead && !ringRise |=> !ring_rise_flag)
        else $error("status read did not clear ring flag");

    a_rts_follow: assert property (
        ctrl.modemControlReg[MCR_RTS_BIT] && !ctrl.modemControlReg[MCR_LOOP_BIT]
        && !autoRts ##1 $stable(ctrl.modemControlReg) |-> !rts_n)
        else $error("rts not active with bit set");

    a_rts_loop: assert property (
        ctrl.modemControlReg[MCR_LOOP_BIT] |=> rts_n)
        else $error("rts active in loop mode");

    a_rts_auto: assert property (
        autoRts && trigHit |=> ##1 rts_n)
        else $error("auto rts did not release at trigger");

    a_mode0_ready: assert property (
        !dmaMode1 && fifoValid |=> !rx_dma_ready_n)
        else $error("mode 0 ready missing with data held");

    a_mode0_idle: assert property (
        !dmaMode1 && !fifoValid |=> rx_dma_ready_n)
        else $error("mode 0 ready with nothing held");

    a_mode1_assert: assert property (
        dmaMode1 && fifoValid && (trigHit || timeoutHit) |=> !rx_dma_ready_n)
        else $error("mode 1 ready missing at trigger");

    a_mode1_hold: assert property (
        dmaMode1 && mode1Active && fifoValid && $stable(dmaMode1)
        |-> !rx_dma_ready_n)
        else $error("mode 1 ready dropped before empty");

    a_mode_force0: assert property (
        !fifoMode |-> !dmaMode1)
        else $error("mode 1 selected without fifos");

    a_tick_only: assert property (
        !tick |=> $stable(rxState))
        else $error("receiver moved off a baud tick");

    c_char_in: cover property (push ##[1:50] pop);
    c_mode1_burst: cover property (dmaMode1 && trigHit ##1 pop ##[1:80] pop);
    c_ring_read: cover property (ringRise ##[1:20] msrRead);
    c_overrun: cover property (overrun);

endmodule

// [core/uart_rx_pkg.sv]
// Shared constants and types for the receive, modem-status and DMA-ready block
package uart_rx_pkg;

    // Host read addresses
    localparam logic [2:0] ADDR_RX_DATA      = 3'h0;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;

    // Modem status field positions
    localparam int MSR_RING_LEVEL_BIT = 6;
    localparam int MSR_RING_RISE_BIT  = 2;

    // Modem control field positions and reset value
    localparam int         MCR_RTS_BIT      = 1;
    localparam int         MCR_LOOP_BIT     = 4;
    localparam int         MCR_AUTOFLOW_BIT = 5;
    localparam logic [7:0] MCR_RESET        = 8'h00;

    // FIFO control field positions and reset value
    localparam int         FCR_ENABLE_BIT     = 0;
    localparam int         FCR_DMA_SELECT_BIT = 3;
    localparam int         FCR_TRIG_LSB       = 6;
    localparam logic [7:0] FCR_RESET          = 8'h00;

    // Receiver framing and timing
    localparam int DATA_W        = 8;
    localparam int FIFO_DEPTH    = 16;
    localparam int OVERSAMPLE    = 16;
    localparam int SAMPLE_MID    = OVERSAMPLE / 2 - 1;
    localparam int CHAR_BITS     = 10;
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_TICKS = TIMEOUT_CHARS * CHAR_BITS * OVERSAMPLE;

    // Receive trigger levels, in characters
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0e;

    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_t;

    // Control bits written by software elsewhere in the UART
    typedef struct packed {
        logic [7:0] modemControlReg;
        logic [7:0] fifoControlReg;
        logic       modemIntEnable;
    } ctrl_t;

    // Host read pins
    typedef struct packed {
        logic       chipSelect;
        logic       readStrobeHigh;
        logic       readStrobeLow_n;
        logic [2:0] addr;
    } host_bus_t;

    // Trigger level lookup
    function automatic logic [4:0] trigLevel(input logic [1:0] sel);
        unique case (sel)
            2'b00: trigLevel = TRIG_L0;
            2'b01: trigLevel = TRIG_L1;
            2'b10: trigLevel = TRIG_L2;
            2'b11: trigLevel = TRIG_L3;
        endcase
    endfunction

endpackage

// [core/pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
    parameter int             W         = 1,
    parameter logic [W-1:0]   RESET_VAL = '0
) (
    input  wire logic         clk,    // System clock
    input  wire logic         rst,    // Async reset, high
    input  wire logic [W-1:0] pinIn,  // Raw pins
    output logic      [W-1:0] pinOut  // Filtered level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Change is taken only once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1     <= RESET_VAL;
            s2     <= RESET_VAL;
            s3     <= RESET_VAL;
            pinOut <= RESET_VAL;
        end else begin
            s1     <= pinIn;
            s2     <= s1;
            s3     <= s2;
            pinOut <= (s2 & s3) | (pinOut & (s2 ^ s3));
        end
    end
endmodule

// [core/rx_fifo.sv]
// Receive FIFO with registered head word
`timescale 1ns/100ps
module rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk,      // System clock
    input  wire logic                     rst,      // Async reset, high
    input  wire logic                     inValid,  // Push request
    output logic                          inReady,  // Room left
    input  wire logic [WIDTH-1:0]         inData,   // Push data
    output logic                          outValid, // Not empty
    input  wire logic                     outReady, // Pop request
    output logic      [WIDTH-1:0]         outData,  // Head word
    output logic      [$clog2(DEPTH+1)-1:0] level   // Words held
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("rx_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic             push;
    logic             pop;
    logic [AW-1:0]    next_rdPtr;

    // Handshake decode
    assign inReady    = level != DEPTH[$clog2(DEPTH+1)-1:0];
    assign outValid   = level != '0;
    assign push       = inValid & inReady;
    assign pop        = outReady & outValid;
    assign next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;

    // Storage array, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers, level and head; bypass keeps head right on push to empty slot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr   <= '0;
            rdPtr   <= '0;
            level   <= '0;
            outData <= '0;
        end else begin
            wrPtr   <= push ? wrPtr + 1'b1 : wrPtr;
            rdPtr   <= next_rdPtr;
            level   <= level + push - pop;
            outData <= (push && wrPtr == next_rdPtr) ? inData : mem[next_rdPtr];
        end
    end
endmodule

// [verif/serial_sender.sv]
// Far-side model: serial line and 16x receive clock
`timescale 1ns/100ps
module serial_sender (
    input  wire logic clk,      // System clock
    input  wire logic rst,      // Reset, high
    output logic      rcvClk16, // 16x baud clock
    output logic      rxLine    // Serial data, idle high
);
    logic [1:0] div;

    ////////////////////////////////////////////////////////////////////////////
    // Free-running 16x clock, four system clocks a phase so the sampler keeps up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div      <= 2'h0;
            rcvClk16 <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) rcvClk16 <= !rcvClk16;
        end
    end

    initial rxLine = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // One 8N1 character, LSB first; changes on the falling tick, away from sampling
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge rcvClk16);
            rxLine <= frame[i];
            repeat (15) @(negedge rcvClk16);
        end
        @(negedge rcvClk16);
        rxLine <= 1'b1;
    endtask
endmodule

// [verif/uart_rx_dma_modem_tb.sv]
// Self-checking bench for receive, ring status, request-to-send and DMA ready
`timescale 1ns/100ps
module uart_rx_dma_modem_tb;
    import uart_rx_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    host_bus_t  hostBus;
    ctrl_t      ctrl;
    logic       ringInd_n;
    logic       rxSerial;
    logic       rcvClk16;
    logic [7:0] dataOut;
    logic       dataOutEn;
    logic       rts_n;
    logic       rx_dma_ready_n;
    logic       modemIrq;
    logic       overrun;
    logic       sawOverrun;
    logic [7:0] rdVal;
    int         nErrors = 0;
    int         samplesChecked = 0;

    always #20 clk = !clk;

    uart_rx_dma_modem #(.DEPTH(16)) dut (.clk(clk), .rst(rst), .hostBus(hostBus),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .ctrl(ctrl), .rxSerial(rxSerial),
        .rcvClk16(rcvClk16), .ringInd_n(ringInd_n), .rts_n(rts_n),
        .rx_dma_ready_n(rx_dma_ready_n), .modemIrq(modemIrq), .overrun(overrun));

    serial_sender pm (.clk(clk), .rst(rst), .rcvClk16(rcvClk16), .rxLine(rxSerial));

    // Overrun is a one-cycle pulse, so latch it for later inspection
    always @(posedge clk) if (overrun === 1'b1) sawOverrun = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Host, control and ring inputs change 1 ns after the rising edge; the serial line changes on the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One host read; address and strobe held until the answer and 4 clocks more
    task automatic hostRead(input logic [2:0] a, input logic useHigh);
        int k;
        hostBus = '{1'b1, useHigh, useHigh, a};
        for (k = 0; k < 20 && dataOutEn !== 1'b1; k++) tick(1);
        check({7'h0, dataOutEn}, 8'h01);
        rdVal = dataOut;
        tick(4);
        hostBus = '{1'b0, 1'b0, 1'b1, a};
        for (k = 0; k < 20 && dataOutEn !== 1'b0; k++) tick(1);
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        check({4'h0, dataOutEn, modemIrq, rx_dma_ready_n, rts_n}, 8'h03);
        check(dataOut, 8'h00);
        $display("reset test done");
    endtask

    task automatic testRts();
        // Unrelated control bits are set too; they must not disturb the pin
        ctrl.modemControlReg = 8'hcb;
        tick(3);
        check({7'h0, rts_n}, 8'h00);
        ctrl.modemControlReg = 8'h12;
        tick(3);
        check({7'h0, rts_n}, 8'h01);
        ctrl.modemControlReg = 8'hc5;
        tick(3);
        check({7'h0, rts_n}, 8'h01);
        $display("rts test done");
    endtask

    // Falling pin alone raises nothing; the rising edge sets the flag, a read clears it
    task automatic testRing();
        ctrl.modemIntEnable = 1'b1;
        ringInd_n = 1'b0;
        tick(8);
        check({7'h0, modemIrq}, 8'h00);
        hostRead(ADDR_MODEM_STATUS, 1'b1);
        check(rdVal, 8'h40);
        ringInd_n = 1'b1;
        tick(8);
        check({7'h0, modemIrq}, 8'h01);
        hostRead(ADDR_MODEM_STATUS, 1'b0);
        check(rdVal, 8'h04);
        check({7'h0, modemIrq}, 8'h00);
        hostRead(ADDR_MODEM_STATUS, 1'b1);
        check(rdVal, 8'h00);
        hostRead(3'h7, 1'b1);
        check(rdVal, 8'h00);
        $display("ring test done");
    endtask

    // Select bit set with FIFOs off must still behave as mode 0
    task automatic testMode0();
        ctrl.fifoControlReg = 8'h3e;
        pm.sendByte(8'ha5);
        tick(20);
        check({7'h0, rx_dma_ready_n}, 8'h00);
        hostRead(ADDR_RX_DATA, 1'b1);
        check(rdVal, 8'ha5);
        check({7'h0, rx_dma_ready_n}, 8'h01);
        ctrl.fifoControlReg = 8'h01;
        pm.sendByte(8'h5a);
        pm.sendByte(8'hc3);
        tick(20);
        hostRead(ADDR_RX_DATA, 1'b1);
        check(rdVal, 8'h5a);
        check({7'h0, rx_dma_ready_n}, 8'h00);
        hostRead(ADDR_RX_DATA, 1'b0);
        check(rdVal, 8'hc3);
        check({7'h0, rx_dma_ready_n}, 8'h01);
        $display("mode 0 test done");
    endtask

    // Trigger 14, auto flow: fill past full, then drain while ready stays low
    task automatic testMode1Fill();
        ctrl.fifoControlReg = 8'hc9;
        ctrl.modemControlReg = 8'h22;
        tick(3);
        check({7'h0, rts_n}, 8'h00);
        for (int i = 0; i < 13; i++) pm.sendByte(8'h10 + 8'(i));
        tick(20);
        check({7'h0, rx_dma_ready_n}, 8'h01);
        pm.sendByte(8'h1d);
        tick(20);
        check({7'h0, rx_dma_ready_n}, 8'h00);
        check({7'h0, rts_n}, 8'h01);
        pm.sendByte(8'h1e);
        pm.sendByte(8'h1f);
        sawOverrun = 1'b0;
        // Seventeenth waits in the holding stage; only the eighteenth is lost
        pm.sendByte(8'h77);
        tick(20);
        check({7'h0, sawOverrun}, 8'h00);
        pm.sendByte(8'h88);
        tick(20);
        check({7'h0, sawOverrun}, 8'h01);
        for (int i = 0; i < 17; i++) begin
            hostRead(ADDR_RX_DATA, 1'b1);
            check(rdVal, (i < 16) ? 8'h10 + 8'(i) : 8'h77);
            if (i < 16) check({7'h0, rx_dma_ready_n}, 8'h00);
        end
        check({7'h0, rx_dma_ready_n}, 8'h01);
        check({7'h0, rts_n}, 8'h00);
        $display("mode 1 fill test done");
    endtask

    // One character below trigger must raise ready only after 640 idle ticks
    task automatic testTimeout();
        pm.sendByte(8'h3c);
        tick(20);
        check({7'h0, rx_dma_ready_n}, 8'h01);
        tick(640 * 8 + 200);
        check({7'h0, rx_dma_ready_n}, 8'h00);
        hostRead(ADDR_RX_DATA, 1'b0);
        check(rdVal, 8'h3c);
        check({7'h0, rx_dma_ready_n}, 8'h01);
        $display("timeout test done");
    endtask

    // Trigger 4: three characters leave ready high, the fourth pulls it low
    task automatic testTrig4();
        ctrl.fifoControlReg = 8'h49;
        for (int i = 0; i < 4; i++) begin
            pm.sendByte(8'h60 + 8'(i));
            tick(20);
            check({7'h0, rx_dma_ready_n}, (i < 3) ? 8'h01 : 8'h00);
        end
        check({7'h0, rts_n}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            hostRead(ADDR_RX_DATA, 1'b1);
            check(rdVal, 8'h60 + 8'(i));
        end
        check({7'h0, rx_dma_ready_n}, 8'h01);
        $display("trigger 4 test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog sized well above the roughly 40000 cycles the tests take
    initial begin
        #(80000 * 40);
        nErrors++;
        report_and_stop();
    end

    initial begin
        hostBus = '{1'b0, 1'b0, 1'b1, 3'h0};
        ctrl = '{8'h00, 8'h00, 1'b0};
        ringInd_n = 1'b1;
        sawOverrun = 1'b0;
        tick(10);
        rst = 1'b0;
        tick(6);
        testReset();
        testRts();
        testRing();
        testMode0();
        testMode1Fill();
        testTimeout();
        testTrig4();
        report_and_stop();
    end
endmodule
